// file: hdl/msc_pkg.sv
// Constants shared by the manual speed control block
`default_nettype none
package msc_pkg;
    // ****************************************
    // Clock and time base
    // ****************************************
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned SPEED_TICK_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * SPEED_TICK_MS;

    // ****************************************
    // Command codes and answer layout
    // ****************************************
    localparam logic [31:0] CMD_READ_MANUAL = 32'h6C746367;
    localparam logic [31:0] CMD_READ_CAL = 32'h6C616367;
    localparam int unsigned N_SPEEDS = 10;
    localparam int unsigned N_TIMEOUTS = N_SPEEDS - 1;
    localparam int unsigned MAN_RSV_BYTES = 9;
    localparam int unsigned CAL_RSV_BYTES = 88;
    localparam int unsigned CRC_BYTES = 2;
    localparam int unsigned MAN_OFS_SPEED = 4;
    localparam int unsigned MAN_OFS_FRAC = MAN_OFS_SPEED + 4 * N_SPEEDS;
    localparam int unsigned MAN_OFS_TIMEOUT = MAN_OFS_FRAC + N_SPEEDS;
    localparam int unsigned MAN_OFS_CLICK = MAN_OFS_TIMEOUT + 2 * N_TIMEOUTS;
    localparam int unsigned MAN_OFS_FLAGS = MAN_OFS_CLICK + 2;
    localparam int unsigned MAN_OFS_SHIFT = MAN_OFS_FLAGS + 2;
    localparam int unsigned MAN_OFS_SHIFT_FRAC = MAN_OFS_SHIFT + 4;
    localparam int unsigned MAN_BODY_BYTES = MAN_OFS_SHIFT_FRAC + 2 + MAN_RSV_BYTES;
    localparam int unsigned MAN_ANS_BYTES = MAN_BODY_BYTES + CRC_BYTES;
    localparam int unsigned CAL_OFS_SLOPE = 4;
    localparam int unsigned CAL_OFS_OFFSET = 8;
    localparam int unsigned CAL_BODY_BYTES = CAL_OFS_OFFSET + 4 + CAL_RSV_BYTES;
    localparam int unsigned CAL_ANS_BYTES = CAL_BODY_BYTES + CRC_BYTES;

    // ****************************************
    // Flags word fields
    // ****************************************
    localparam int unsigned FLAG_MODE_LSB = 0;
    localparam int unsigned FLAG_LEFT_OPEN = 2;
    localparam int unsigned FLAG_RIGHT_OPEN = 3;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_STICK = 2'h1,
        MODE_BUTTONS = 2'h2,
        MODE_UNUSED = 2'h3
    } msc_mode_t;

    // ****************************************
    // Fixed-point scaling
    // ****************************************
    localparam int unsigned CAL_FRAC_BITS = 16;
    localparam int unsigned STICK_FRAC_BITS = 15;
    localparam logic [3:0] DIV_MAX = 4'h8;
endpackage
`default_nettype wire

// file: hdl/msc_speed_ramp.sv
// Speed ramp that walks the actual speed toward the target at a fixed rate
`default_nettype none
module msc_speed_ramp
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic tick,
    input wire logic signed [31:0] target,
    input wire logic [31:0] stepPerTick,
    // Result
    output logic signed [31:0] actual_q
);
    logic signed [31:0] actual_d;
    logic signed [32:0] gap;

    always_comb begin
        gap = 33'(target) - 33'(actual_q);
        actual_d = actual_q;
        // Usual acceleration, never a jump to the new speed
        if (tick) begin
            if (gap > 33'(signed'({1'b0, stepPerTick}))) begin
                actual_d = 32'(actual_q + signed'(stepPerTick));
            end else if (-gap > 33'(signed'({1'b0, stepPerTick}))) begin
                actual_d = 32'(actual_q - signed'(stepPerTick));
            end else begin
                actual_d = target;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            actual_q <= 32'sh0;
        end else begin
            actual_q <= actual_d;
        end
    end
endmodule
`default_nettype wire

// file: hdl/msc_manual_ctrl.sv
// Manual speed control: panel handling, settings read-back, current scaling
//
// Functional notes
// - Current is slope times ADC code plus offset
// - Calibration answer ends offset, 88 reserved, checksum
// - Manual settings read by code; answer echoes it
// - Shift reported as full steps plus fraction
// - Speed table with fraction companions for manual motion
// - Mode field: off, joystick, or buttons
// - Open-contact flags invert left and right buttons
// - Joystick full displacement seeks indexed table speed
// - Button click starts motion at first speed
// - After timeout i, move to entry i+1
// - Speed changes ramp, never jump
// - Manual answer ends 9 reserved, checksum
`default_nettype none
module msc_manual_ctrl
    import msc_pkg::*;
#(
    parameter int unsigned MS_CYCLES_P = MS_CYCLES,
    parameter int unsigned ADC_W = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Manual control settings
    input wire logic [N_SPEEDS-1:0][31:0] speedTableFull,
    input wire logic [N_SPEEDS-1:0][7:0] speedTableFraction,
    input wire logic [N_TIMEOUTS-1:0][15:0] stepTimeoutMs,
    input wire logic [15:0] clickHoldLimit,
    input wire logic [15:0] controlFlags,
    input wire logic signed [31:0] shiftFullSteps,
    input wire logic signed [15:0] shiftFraction,
    input wire logic [3:0] stepDivisionSetting,
    input wire logic [31:0] accelPerMs,
    // Operator panel
    input wire logic leftContact,
    input wire logic rightContact,
    input wire logic signed [15:0] stickPosition,
    // Current calibration
    input wire logic signed [31:0] totalCurrentSlope,
    input wire logic signed [31:0] totalCurrentOffset,
    input wire logic [ADC_W-1:0] adcCode,
    input wire logic adcValid,
    // Host command stream
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    output logic rxReady_q,
    output logic txValid_q,
    output logic [7:0] txByte_q,
    input wire logic txReady,
    // Status
    output logic signed [31:0] targetSpeed_q,
    output logic signed [31:0] actualSpeed_q,
    output logic [3:0] speedIndex_q,
    output logic moving_q,
    output logic signed [31:0] totalCurrentMa_q,
    output logic signed [47:0] shiftMicrosteps_q
);
    if (N_SPEEDS < 2 || N_SPEEDS > 16 || MS_CYCLES_P < 1 || ADC_W > 30) begin : g_check
        $error("msc_manual_ctrl: unsupported parameter values");
    end

    // ****************************************
    // Settings read-back
    // ****************************************
    typedef enum logic [0:0] {
        HS_COLLECT = 1'b0,
        HS_SEND = 1'b1
    } msc_host_t;

    msc_host_t hostSt_q, hostSt_d;
    logic [1:0] rxCount_q, rxCount_d;
    logic [31:0] cmdWord_q, cmdWord_d;
    logic [31:0] fullWord;
    logic ansCal_q, ansCal_d;
    logic [6:0] ansIdx_q, ansIdx_d;
    logic [15:0] sum_q, sum_d;
    logic rxReady_d, txValid_d;
    logic [7:0] txByte_d;
    logic [8*MAN_BODY_BYTES-1:0] manBody;
    logic [8*CAL_BODY_BYTES-1:0] calBody;
    logic [6:0] ansLast;

    // Little-endian record images, taken live from the settings inputs
    always_comb begin
        manBody = '0;
        manBody[31:0] = CMD_READ_MANUAL;
        for (int i = 0; i < N_SPEEDS; i++) begin
            manBody[8*(MAN_OFS_SPEED+4*i) +: 32] = speedTableFull[i];
            manBody[8*(MAN_OFS_FRAC+i) +: 8] = speedTableFraction[i];
        end
        for (int i = 0; i < N_TIMEOUTS; i++) begin
            manBody[8*(MAN_OFS_TIMEOUT+2*i) +: 16] = stepTimeoutMs[i];
        end
        manBody[8*MAN_OFS_CLICK +: 16] = clickHoldLimit;
        manBody[8*MAN_OFS_FLAGS +: 16] = controlFlags;
        manBody[8*MAN_OFS_SHIFT +: 32] = shiftFullSteps;
        manBody[8*MAN_OFS_SHIFT_FRAC +: 16] = shiftFraction;
        calBody = '0;
        calBody[31:0] = CMD_READ_CAL;
        calBody[8*CAL_OFS_SLOPE +: 32] = totalCurrentSlope;
        calBody[8*CAL_OFS_OFFSET +: 32] = totalCurrentOffset;
    end

    function automatic logic [7:0] bodyByte(input logic cal, input logic [6:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (cal) begin
            b = calBody[{idx, 3'b000} +: 8];
        end else if (idx < 7'(MAN_BODY_BYTES)) begin
            b = manBody[{idx, 3'b000} +: 8];
        end
        return b;
    endfunction

    always_comb begin
        hostSt_d = hostSt_q;
        rxCount_d = rxCount_q;
        cmdWord_d = cmdWord_q;
        ansCal_d = ansCal_q;
        ansIdx_d = ansIdx_q;
        sum_d = sum_q;
        rxReady_d = rxReady_q;
        txValid_d = txValid_q;
        txByte_d = txByte_q;
        fullWord = {rxByte, cmdWord_q[31:8]};
        ansLast = ansCal_q ? 7'(CAL_ANS_BYTES - 1) : 7'(MAN_ANS_BYTES - 1);
        unique case (hostSt_q)
            HS_COLLECT: begin
                if (rxValid && rxReady_q) begin
                    cmdWord_d = fullWord;
                    rxCount_d = 2'(rxCount_q + 2'h1);
                    // Only a known code opens an answer; others are dropped
                    if (rxCount_q == 2'h3 && (fullWord == CMD_READ_MANUAL ||
                            fullWord == CMD_READ_CAL)) begin
                        hostSt_d = HS_SEND;
                        ansCal_d = (fullWord == CMD_READ_CAL);
                        ansIdx_d = 7'h00;
                        sum_d = 16'h0000;
                        rxReady_d = 1'b0;
                        txValid_d = 1'b1;
                        txByte_d = fullWord[7:0];
                    end
                end
            end
            HS_SEND: begin
                if (txReady) begin
                    ansIdx_d = 7'(ansIdx_q + 7'h01);
                    if (ansIdx_q < ansLast - 7'h01) begin
                        sum_d = 16'(sum_q + {8'h00, txByte_q});
                    end
                    if (ansIdx_q == ansLast) begin
                        hostSt_d = HS_COLLECT;
                        rxCount_d = 2'h0;
                        rxReady_d = 1'b1;
                        txValid_d = 1'b0;
                        txByte_d = 8'h00;
                    end else if (ansIdx_d == ansLast - 7'h01) begin
                        txByte_d = sum_d[7:0];
                    end else if (ansIdx_d == ansLast) begin
                        txByte_d = sum_q[15:8];
                    end else begin
                        txByte_d = bodyByte(ansCal_q, ansIdx_d);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hostSt_q <= HS_COLLECT;
            rxCount_q <= 2'h0;
            cmdWord_q <= 32'h0000_0000;
            ansCal_q <= 1'b0;
            ansIdx_q <= 7'h00;
            sum_q <= 16'h0000;
            rxReady_q <= 1'b0;
            txValid_q <= 1'b0;
            txByte_q <= 8'h00;
        end else begin
            hostSt_q <= hostSt_d;
            rxCount_q <= rxCount_d;
            cmdWord_q <= cmdWord_d;
            ansCal_q <= ansCal_d;
            ansIdx_q <= ansIdx_d;
            sum_q <= sum_d;
            rxReady_q <= (hostSt_q == HS_COLLECT && !rxReady_q) ? 1'b1 : rxReady_d;
            txValid_q <= txValid_d;
            txByte_q <= txByte_d;
        end
    end

    // ****************************************
    // Panel and speed selection
    // ****************************************
    typedef enum logic [1:0] {
        BT_IDLE = 2'h0,
        BT_CLICK = 2'h1,
        BT_RUN = 2'h2
    } msc_button_t;

    msc_button_t btSt_q, btSt_d;
    logic [2:0] leftSync_q, leftSync_d, rightSync_q, rightSync_d;
    logic leftLevel_q, leftLevel_d, rightLevel_q, rightLevel_d;
    logic leftPushed, rightPushed, leftPushedOld_q, rightPushedOld_q;
    logic [31:0] tickCnt_q, tickCnt_d;
    logic msTick;
    logic [15:0] msCount_q, msCount_d;
    logic [3:0] btIdx_q, btIdx_d, stickIdx_q, stickIdx_d;
    logic dirRight_q, dirRight_d;
    msc_mode_t mode;
    logic [3:0] div;
    logic [31:0] stickSpeed, btSpeed;
    logic signed [48:0] stickProd;
    logic signed [31:0] target_d;
    logic [3:0] speedIndex_d;
    logic signed [47:0] shiftMicro_d;

    // Microstep speed for a table entry at the current division
    function automatic logic [31:0] microSpeed(input logic [3:0] idx, input logic [3:0] d);
        logic [39:0] s;
        logic [7:0] fracMask;
        fracMask = 8'(9'h001 << d) - 8'h01;
        s = 40'(speedTableFull[idx]) << d;
        s = s | 40'(speedTableFraction[idx] & fracMask);
        return (s > 40'h00_7FFF_FFFF) ? 32'h7FFF_FFFF : s[31:0];
    endfunction

    always_comb begin
        mode = msc_mode_t'(controlFlags[FLAG_MODE_LSB +: 2]);
        div = (stepDivisionSetting > DIV_MAX) ? DIV_MAX : stepDivisionSetting;
        // Three-stage sync; level moves only when the last two agree
        leftSync_d = {leftSync_q[1:0], leftContact};
        rightSync_d = {rightSync_q[1:0], rightContact};
        leftLevel_d = (leftSync_q[1] == leftSync_q[2]) ? leftSync_q[2] : leftLevel_q;
        rightLevel_d = (rightSync_q[1] == rightSync_q[2]) ? rightSync_q[2] : rightLevel_q;
        // Level high means contact closed
        leftPushed = controlFlags[FLAG_LEFT_OPEN] ? !leftLevel_q : leftLevel_q;
        rightPushed = controlFlags[FLAG_RIGHT_OPEN] ? !rightLevel_q : rightLevel_q;
        msTick = (tickCnt_q == 32'(MS_CYCLES_P - 1));
        tickCnt_d = msTick ? 32'h0000_0000 : 32'(tickCnt_q + 32'h1);
        btSt_d = btSt_q;
        msCount_d = msCount_q;
        btIdx_d = btIdx_q;
        stickIdx_d = stickIdx_q;
        dirRight_d = dirRight_q;
        if (mode == MODE_BUTTONS) begin
            unique case (btSt_q)
                BT_IDLE: begin
                    if (leftPushed != rightPushed) begin
                        btSt_d = BT_CLICK;
                        dirRight_d = rightPushed;
                        msCount_d = 16'h0000;
                    end
                end
                BT_CLICK: begin
                    if (leftPushed == rightPushed) begin
                        btSt_d = BT_IDLE;
                    end else if (msCount_q >= clickHoldLimit) begin
                        btSt_d = BT_RUN;
                        btIdx_d = 4'h0;
                        msCount_d = 16'h0000;
                    end else if (msTick) begin
                        msCount_d = 16'(msCount_q + 16'h1);
                    end
                end
                BT_RUN: begin
                    if (leftPushed == rightPushed) begin
                        btSt_d = BT_IDLE;
                    end else if (msTick) begin
                        msCount_d = 16'(msCount_q + 16'h1);
                        if (btIdx_q < 4'(N_SPEEDS - 1) &&
                                msCount_d >= stepTimeoutMs[btIdx_q]) begin
                            btIdx_d = 4'(btIdx_q + 4'h1);
                            msCount_d = 16'h0000;
                        end
                    end
                end
                default: begin
                    btSt_d = BT_IDLE;
                end
            endcase
        end else begin
            // Step timeouts have no effect outside button mode
            btSt_d = BT_IDLE;
            msCount_d = 16'h0000;
            if (mode == MODE_STICK) begin
                if (leftPushed && !leftPushedOld_q && stickIdx_q != 4'h0) begin
                    stickIdx_d = 4'(stickIdx_q - 4'h1);
                end else if (rightPushed && !rightPushedOld_q &&
                        stickIdx_q < 4'(N_SPEEDS - 1)) begin
                    stickIdx_d = 4'(stickIdx_q + 4'h1);
                end
            end
        end
        stickSpeed = microSpeed(stickIdx_q, div);
        btSpeed = microSpeed(btIdx_q, div);
        // Full displacement scales to the indexed speed
        stickProd = signed'({17'h0_0000, stickSpeed}) * 49'(stickPosition);
        target_d = 32'sh0;
        speedIndex_d = 4'h0;
        unique case (mode)
            MODE_STICK: begin
                target_d = 32'(stickProd >>> STICK_FRAC_BITS);
                speedIndex_d = stickIdx_q;
            end
            MODE_BUTTONS: begin
                if (btSt_q == BT_RUN) begin
                    target_d = dirRight_q ? signed'(btSpeed) : -signed'(btSpeed);
                end
                speedIndex_d = btIdx_q;
            end
            MODE_OFF, MODE_UNUSED: begin
                target_d = 32'sh0;
            end
        endcase
        shiftMicro_d = (48'(shiftFullSteps) <<< div) +
            48'(signed'(shiftFraction));
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            leftSync_q <= 3'h0;
            rightSync_q <= 3'h0;
            leftLevel_q <= 1'b0;
            rightLevel_q <= 1'b0;
            leftPushedOld_q <= 1'b0;
            rightPushedOld_q <= 1'b0;
            tickCnt_q <= 32'h0000_0000;
            btSt_q <= BT_IDLE;
            msCount_q <= 16'h0000;
            btIdx_q <= 4'h0;
            stickIdx_q <= 4'h0;
            dirRight_q <= 1'b0;
            targetSpeed_q <= 32'sh0;
            speedIndex_q <= 4'h0;
            moving_q <= 1'b0;
            shiftMicrosteps_q <= 48'sh0;
        end else begin
            leftSync_q <= leftSync_d;
            rightSync_q <= rightSync_d;
            leftLevel_q <= leftLevel_d;
            rightLevel_q <= rightLevel_d;
            leftPushedOld_q <= leftPushed;
            rightPushedOld_q <= rightPushed;
            tickCnt_q <= tickCnt_d;
            btSt_q <= btSt_d;
            msCount_q <= msCount_d;
            btIdx_q <= btIdx_d;
            stickIdx_q <= stickIdx_d;
            dirRight_q <= dirRight_d;
            targetSpeed_q <= target_d;
            speedIndex_q <= speedIndex_d;
            moving_q <= (actualSpeed_q != 32'sh0) || (target_d != 32'sh0);
            shiftMicrosteps_q <= shiftMicro_d;
        end
    end

    msc_speed_ramp u_ramp (
        .clock(clock),
        .resetn(resetn),
        .tick(msTick),
        .target(targetSpeed_q),
        .stepPerTick(accelPerMs),
        .actual_q(actualSpeed_q)
    );

    // ****************************************
    // Current scaling
    // ****************************************
    logic signed [63:0] currentProd;
    logic signed [31:0] current_d;

    always_comb begin
        currentProd = 64'(totalCurrentSlope) * 64'(signed'({1'b0, adcCode}));
        current_d = totalCurrentMa_q;
        if (adcValid) begin
            current_d = 32'((currentProd + 64'(totalCurrentOffset)) >>> CAL_FRAC_BITS);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            totalCurrentMa_q <= 32'sh0;
        end else begin
            totalCurrentMa_q <= current_d;
        end
    end
endmodule
`default_nettype wire

// file: verif/msc_manual_chk.sv
// Assertions on the manual speed control ports
`default_nettype none
module msc_manual_chk
    import msc_pkg::*;
#(
    parameter int unsigned ADC_W = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Settings and calibration
    input wire logic [15:0] controlFlags,
    input wire logic [31:0] accelPerMs,
    input wire logic signed [31:0] totalCurrentSlope,
    input wire logic signed [31:0] totalCurrentOffset,
    input wire logic [ADC_W-1:0] adcCode,
    input wire logic adcValid,
    // Host stream
    input wire logic rxReady_q,
    input wire logic txValid_q,
    input wire logic [7:0] txByte_q,
    input wire logic txReady,
    // Status
    input wire logic signed [31:0] targetSpeed_q,
    input wire logic signed [31:0] actualSpeed_q,
    input wire logic [3:0] speedIndex_q,
    input wire logic signed [31:0] totalCurrentMa_q
);
    logic signed [31:0] curExp;
    logic signed [32:0] accS;
    logic offMode;
    assign curExp = 32'((64'(totalCurrentSlope) * $signed({1'b0, adcCode})
        + 64'(totalCurrentOffset)) >>> 16);
    assign accS = $signed({1'b0, accelPerMs});
    assign offMode = controlFlags[0] == controlFlags[1];
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_txHold; txValid_q && !txReady |=> txValid_q && $stable(txByte_q); endproperty
    a_txHold: assert property (p_txHold) else $error("tx byte not held");
    property p_rxQuiet; txValid_q |-> !rxReady_q; endproperty
    a_rxQuiet: assert property (p_rxQuiet) else $error("rx open while answering");
    property p_echo; $rose(txValid_q) |-> txByte_q == 8'h67; endproperty
    a_echo: assert property (p_echo) else $error("answer not led by code");
    property p_rxBack; $fell(txValid_q) |-> rxReady_q; endproperty
    a_rxBack: assert property (p_rxBack) else $error("rx not reopened");
    property p_cur; adcValid |=> totalCurrentMa_q == $past(curExp); endproperty
    a_cur: assert property (p_cur) else $error("current wrong");
    property p_ramp;
        (33'(actualSpeed_q) - 33'($past(actualSpeed_q)) <= accS)
            && (33'($past(actualSpeed_q)) - 33'(actualSpeed_q) <= accS);
    endproperty
    a_ramp: assert property (p_ramp) else $error("speed jumped");
    property p_offTgt; offMode [*4] |-> targetSpeed_q == 32'sh0; endproperty
    a_offTgt: assert property (p_offTgt) else $error("motion while off");
    property p_offIdx; offMode [*4] |-> speedIndex_q == 4'h0; endproperty
    a_offIdx: assert property (p_offIdx) else $error("index while off");
endmodule
bind msc_manual_ctrl msc_manual_chk #(.ADC_W(ADC_W)) msc_manual_chk_inst (.*);
`default_nettype wire

// file: verif/msc_host_model.sv
// Host model: sends codes, collects answer bytes
`default_nettype none
module msc_host_model (
    // Clock
    input wire logic clock,
    // Command bytes out
    output logic rxValid,
    output logic [7:0] rxByte,
    input wire logic rxReady_q,
    // Answer bytes in
    input wire logic txValid_q,
    input wire logic [7:0] txByte_q,
    output logic txReady,
    // Random stalls on
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h4b5338d8;
    logic [7:0] got[$];
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h5A;
        txReady = 1'b0;
    end
    // Code only, low byte first
    task send_cmd(input logic [31:0] code);
        rxValid = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rxByte = code[8*i+:8];
            do @(negedge clock); while (rxReady_q !== 1'b1);
            @(posedge clock);
            #1;
        end
        rxValid = 1'b0;
        rxByte = ~code[31:24];
    endtask
    // Stalls test byte holding
    always @(posedge clock) #1 txReady = slow ? 1'($random(seed)) : 1'b1;
    always @(negedge clock) if (txValid_q && txReady) got.push_back(txByte_q);
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Testbench for the manual speed control block
`default_nettype none
module testbench;
    import msc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [N_SPEEDS-1:0][31:0] speedTableFull;
    logic [N_SPEEDS-1:0][7:0] speedTableFraction;
    logic [N_TIMEOUTS-1:0][15:0] stepTimeoutMs;
    logic [15:0] clickHoldLimit, controlFlags;
    logic signed [31:0] shiftFullSteps, totalCurrentSlope, totalCurrentOffset;
    logic signed [15:0] shiftFraction, stickPosition;
    logic [3:0] stepDivisionSetting, speedIndex_q;
    logic [31:0] accelPerMs;
    logic leftContact, rightContact, adcValid, rxValid, rxReady_q, txValid_q, txReady;
    logic moving_q, slow;
    logic [11:0] adcCode;
    logic [7:0] rxByte, txByte_q;
    logic signed [31:0] targetSpeed_q, actualSpeed_q, totalCurrentMa_q;
    logic signed [47:0] shiftMicrosteps_q;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 32'h4b5338d8;
    logic [7:0] ex[$];
    always #4 clock = ~clock;
    msc_manual_ctrl #(.MS_CYCLES_P(10)) msc_manual_ctrl_inst (.*);
    msc_host_model host_inst (.*);
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk(input logic ok, input string w);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, w);
        end
    endtask
    task put(input logic [8*CAL_BODY_BYTES-1:0] v, input int n);
        for (int i = 0; i < n; i++) ex.push_back(v[8*i+:8]);
    endtask
    // Additive checksum, low byte first
    task ask(input logic [31:0] code);
        logic [15:0] s;
        s = 16'h0;
        foreach (ex[i]) s += 16'(ex[i]);
        put(800'(s), 2);
        host_inst.got.delete();
        host_inst.send_cmd(code);
        for (int i = 0; i < 1000 && host_inst.got.size() < ex.size(); i++) cyc(1);
        cyc(3);
        chk(host_inst.got.size() == ex.size(), "length");
        foreach (ex[i]) chk(host_inst.got[i] === ex[i], "byte");
        ex.delete();
    endtask
    task waitv(input logic signed [31:0] e, input int n, input string w);
        for (int i = 0; i < n && targetSpeed_q !== e; i++) cyc(1);
        chk(targetSpeed_q === e, w);
    endtask
    function logic signed [31:0] uspd(input int i);
        logic [7:0] m;
        m = (8'h1 << stepDivisionSetting) - 8'h1;
        return (speedTableFull[i] << stepDivisionSetting) | 32'(speedTableFraction[i] & m);
    endfunction
    function logic signed [31:0] stk(input int i);
        return 32'((64'(uspd(i)) * 64'sh7FFF) >>> 15);
    endfunction
    task print_verdict();
        $display("cmp %0d err %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < N_SPEEDS; i++) begin
            speedTableFull[i] = 32'({$random(seed)} % 100000 + 1);
            speedTableFraction[i] = 8'($random(seed));
            if (i < N_TIMEOUTS) stepTimeoutMs[i] = 16'(2 + {$random(seed)} % 3);
        end
        speedTableFull[N_SPEEDS-1] = 32'h186A0;
        clickHoldLimit = 16'h4;
        controlFlags = 16'($random(seed)) & 16'hFFFC;
        shiftFullSteps = $random(seed);
        shiftFraction = 16'($random(seed));
        stepDivisionSetting = 4'h3;
        accelPerMs = 32'h4000;
        {leftContact, rightContact, adcValid, slow} = 4'h1;
        stickPosition = 16'h0;
        adcCode = 12'h0;
        totalCurrentSlope = $random(seed);
        totalCurrentOffset = $random(seed);
        repeat (16) @(posedge clock);
        #1 resetn = 1'b1;
        cyc(2);
        host_inst.send_cmd(32'h11223344);
        put(800'({shiftFraction, shiftFullSteps, controlFlags, clickHoldLimit, stepTimeoutMs,
            speedTableFraction, speedTableFull, CMD_READ_MANUAL}), MAN_BODY_BYTES);
        ask(CMD_READ_MANUAL);
        slow = 1'b0;
        put(800'({totalCurrentOffset, totalCurrentSlope, CMD_READ_CAL}), CAL_BODY_BYTES);
        ask(CMD_READ_CAL);
        for (int k = 0; k < 4; k++) begin
            adcCode = (k == 0) ? 12'hFFF : 12'($random(seed));
            adcValid = 1'b1;
            cyc(1);
            adcValid = 1'b0;
            cyc(1);
            chk(totalCurrentMa_q === 32'((64'(totalCurrentSlope) * $signed({1'b0, adcCode})
                + 64'(totalCurrentOffset)) >>> 16), "current");
        end
        for (int k = 0; k < 4; k++) begin
            stepDivisionSetting = 4'(k * 3);
            cyc(3);
            chk(shiftMicrosteps_q === (48'(shiftFullSteps) <<< (k == 3 ? 8 : k * 3))
                + 48'(shiftFraction), "shift");
        end
        stepDivisionSetting = 4'h3;
        stickPosition = 16'h7FFF;
        controlFlags = 16'h1;
        waitv(stk(0), 40, "stick");
        rightContact = 1'b1;
        cyc(300);
        chk(speedIndex_q === 4'h1, "stick index");
        waitv(stk(1), 40, "stick step");
        for (int m = 0; m < 4; m += 3) begin
            controlFlags = 16'(m);
            cyc(60);
            chk(targetSpeed_q === 32'sh0 && speedIndex_q === 4'h0, "off");
        end
        for (int k = 0; k < 4; k++) begin
            logic op, lf;
            logic signed [31:0] sg;
            {lf, op} = 2'(k);
            sg = lf ? -32'sh1 : 32'sh1;
            controlFlags = 16'h2 | (op ? (lf ? 16'h4 : 16'h8) : 16'h0);
            leftContact = lf & op;
            rightContact = !lf & op;
            cyc(30);
            if (lf) leftContact = !op;
            else rightContact = !op;
            cyc(25);
            chk(targetSpeed_q === 32'sh0, "early speed");
            waitv(sg * uspd(0), 45, "first speed");
            waitv(sg * uspd(1), 10 * stepTimeoutMs[0] + 20, "next speed");
            waitv(sg * uspd(9), 600, "last speed");
            chk(speedIndex_q === 4'h9 && moving_q === 1'b1, "index top");
            leftContact = lf & op;
            rightContact = !lf & op;
            waitv(32'sh0, 30, "release");
        end
        print_verdict();
    end
endmodule
`default_nettype wire
